// >>> common/tpcsf_pkg.sv
// shared constants of the transceiver pcs fabric datapath
package tpcsf_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
   localparam logic [7:0]  STATUS_OFFSET = 8'h04;

   // control fields
   localparam int          CTRL_DESER_EN_BIT  = 0;
   localparam int          CTRL_SER_EN_BIT    = 1;
   localparam int          CTRL_ENC_BYPASS_BIT = 2;
   localparam int          CTRL_RX_MODE_LSB   = 3;
   localparam int          CTRL_RX_RST_BIT    = 5;
   localparam int          CTRL_TX_RST_BIT    = 6;
   localparam int          CTRL_WIDTH         = 7;
   localparam logic [6:0]  CTRL_RESET         = 7'h03;

   // status fields
   localparam int          STAT_RX_OVF_BIT    = 0;
   localparam int          STAT_TX_UNF_BIT    = 1;
   localparam int          STAT_RX_LEVEL_LSB  = 4;
   localparam int          STAT_TX_LEVEL_LSB  = 8;
   localparam int          STAT_SYNC_BIT      = 12;
   localparam int          STAT_RD_BIT        = 13;

   // receive input sets
   localparam logic [1:0]  RX_MODE_8_3  = 2'h0;
   localparam logic [1:0]  RX_MODE_8_5  = 2'h1;
   localparam logic [1:0]  RX_MODE_10_2 = 2'h2;

   // widths and depths
   localparam int          RX_SYM_W   = 13;
   localparam int          RX_WORD_W  = 26;
   localparam int          TX_BYTE_W  = 13;
   localparam int          FIFO_DEPTH = 4;
   localparam logic [1:0]  SYNC_COUNT = 2'h3;

   // bus answers
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // negative-disparity comma, code bit a in bit 9
   localparam logic [9:0]  K28_5_NEG = 10'b0011111010;
   localparam logic [7:0]  K28_5_BYTE = 8'hbc;

endpackage

// >>> hdl/tpcsf_encoder.sv
// 8b/10b encoder with reset comma and running disparity
module tpcsf_encoder
   import tpcsf_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   input  wire logic       tx_rst,
   input  wire logic       go,
   input  wire logic       send_comma,
   input  wire logic       raw,
   input  wire logic [9:0] data_in,
   input  wire logic       ctrl_in,
   input  wire logic       force_disp,
   input  wire logic       force_val,
   output logic [9:0]      sym_out,
   output logic            rd_pos
);

   typedef struct packed {
      logic [9:0] sym;
      logic       rd;
   } tpcsf_enc_state_t;

   tpcsf_enc_state_t q, d;

   // ----------------------------------------------------------------
   // code tables, negative column, first-sent bit in msb
   // ----------------------------------------------------------------
   function automatic logic [5:0] tab6(input logic [4:0] x);
      logic [5:0] t [32];
      t = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
            6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
            6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
            6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
      return t[x];
   endfunction

   function automatic logic [3:0] tab4(input logic [2:0] y);
      logic [3:0] t [8];
      t = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
      return t[y];
   endfunction

   // one symbol: standard tables, column picked by disparity
   function automatic logic [10:0] encode(input logic [7:0] b, input logic k,
                                          input logic rd);
      logic [4:0] x;
      logic [2:0] y;
      logic [5:0] c6;
      logic [3:0] c4;
      logic       unb6;
      logic       mid;
      logic       alt;
      logic       unb4;
      x    = b[4:0];
      y    = b[7:5];
      c6   = (k && x == 5'h1c) ? 6'h0f : tab6(x);
      unb6 = ($countones(c6) != 3);
      if (rd && (unb6 || x == 5'h07)) begin
         c6 = ~c6;
      end
      mid  = rd ^ unb6;
      alt  = (y == 3'h7) && (k || (!mid && (x == 5'h11 || x == 5'h12 || x == 5'h14))
              || (mid && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
      c4   = alt ? 4'h7 : tab4(y);
      unb4 = (y == 3'h0) || (y == 3'h4) || (y == 3'h7);
      if (mid && (unb4 || y == 3'h3)) begin
         c4 = ~c4;
      end else if (k && !mid && !unb4 && y != 3'h3) begin
         c4 = ~c4;
      end
      return {c6, c4, mid ^ unb4};
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [10:0] e;
      logic        rd_use;
      d      = q;
      rd_use = force_disp ? force_val : q.rd;
      e      = encode(send_comma ? K28_5_BYTE : data_in[7:0],
                      send_comma | ctrl_in, send_comma ? q.rd : rd_use);
      if (tx_rst) begin
         d.sym = K28_5_NEG;
         d.rd  = 1'b0;
      end else if (go) begin
         if (raw && !send_comma) begin
            d.sym = data_in;
         end else begin
            d.sym = e[10:1];
            d.rd  = e[0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q     <= '0;
         q.sym <= K28_5_NEG;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign sym_out = q.sym;
   assign rd_pos  = q.rd;

endmodule

// >>> hdl/tpcsf_datapath.sv
// fabric-side transceiver datapath: deserializer, fifos, serializer
// ----------------------------------------------------------------
// Summary of operation
// - deserializer takes at most 13 bits of data plus flags per symbol.
// - input sets are 8+3 flags, 8+5 flags or 10+2 flags.
// - output is up to 26 bits, each flag doubled for upper and lower byte.
// - in 10-to-20 mode alignment flag bit 1 marks upper, bit 0 lower half.
// - receive fifo is four words, at fabric edge, phase only, never bypassed.
// - receive fifo written at half symbol rate when deserializing, read by fabric.
// - transmit fifo is four words, always used, fabric writes, pll side reads.
// - control select and disparity override travel through the fifo with data.
// - serializer splits each wide word into two, low byte first.
// - encoder maps byte plus control select to a balanced ten-bit code.
// - in transmit reset, disparity cleared, inputs ignored, negative comma sent.
// - after reset start negative and send three commas before data.
// - control select low encodes data, high encodes a control symbol.
// - encoder does not check control bytes for legality.
// - negative comma is 0011111010, positive form its complement.
// - receive digital reset reinitialises a collided receive fifo.
// ----------------------------------------------------------------
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
module tpcsf_datapath
   import tpcsf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)
(
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 clk_en,
   // register bus
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // digital resets
   input  wire logic                 rx_digital_rst,
   input  wire logic                 tx_digital_rst,
   // receive side
   input  wire logic                 rx_sym_valid,
   input  wire logic [RX_SYM_W-1:0]  rx_sym_in,
   output logic                      rx_out_valid,
   input  wire logic                 rx_out_ready,
   output logic [RX_WORD_W-1:0]      rx_out_word,
   // transmit side
   input  wire logic                 tx_in_valid,
   output logic                      tx_in_ready,
   input  wire logic [19:0]          tx_in_data,
   input  wire logic [1:0]           tx_in_ctrl,
   input  wire logic [1:0]           tx_in_force,
   input  wire logic [1:0]           tx_in_fval,
   input  wire logic                 tx_sym_strobe,
   output logic [9:0]                tx_sym_out
);

   localparam int PW = $clog2(DEPTH) + 1;

   typedef struct packed {
      logic [CTRL_WIDTH-1:0]                  ctrl;
      logic                                   rx_ovf;
      logic                                   tx_unf;
      logic                                   aw_got;
      logic [7:0]                             awaddr;
      logic                                   w_got;
      logic [31:0]                            wdata;
      logic [3:0]                             wstrb;
      logic                                   bvalid;
      logic [1:0]                             bresp;
      logic                                   rvalid;
      logic [31:0]                            rdata;
      logic [1:0]                             rresp;
      logic [DEPTH-1:0][RX_WORD_W-1:0]        rx_mem;
      logic [PW-1:0]                          rx_wp;
      logic [PW-1:0]                          rx_rp;
      logic                                   rx_half;
      logic [RX_SYM_W-1:0]                    rx_lo;
      logic [DEPTH-1:0][2*TX_BYTE_W-1:0]      tx_mem;
      logic [PW-1:0]                          tx_wp;
      logic [PW-1:0]                          tx_rp;
      logic                                   tx_phase;
      logic [TX_BYTE_W-1:0]                   tx_hi;
      logic [1:0]                             sync_cnt;
   } tpcsf_state_t;

   tpcsf_state_t q, d;

   logic             rx_rst;
   logic             tx_rst;
   logic             enc_go;
   logic             enc_comma;
   logic [TX_BYTE_W-1:0] enc_byte;
   logic             enc_rd;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // places data halves then each flag pair, upper copy above lower
   function automatic logic [RX_WORD_W-1:0] deser_pack(input logic [RX_SYM_W-1:0] lo,
                                                        input logic [RX_SYM_W-1:0] hi,
                                                        input logic [1:0] mode);
      logic [RX_WORD_W-1:0] r;
      int                   dw;
      int                   nf;
      r  = '0;
      dw = (mode == RX_MODE_10_2) ? 10 : 8;
      nf = (mode == RX_MODE_8_3) ? 3 : (mode == RX_MODE_8_5) ? 5 : 2;
      for (int i = 0; i < 10; i++) begin
         if (i < dw) begin
            r[i]      = lo[i];
            r[dw + i] = hi[i];
         end
      end
      for (int j = 0; j < 5; j++) begin
         if (j < nf) begin
            r[2*dw + 2*j]     = lo[dw + j];
            r[2*dw + 2*j + 1] = hi[dw + j];
         end
      end
      return r;
   endfunction

   function automatic logic [PW-1:0] fifo_level(input logic [PW-1:0] wp,
                                                input logic [PW-1:0] rp);
      return wp - rp;
   endfunction

   function automatic logic [PW-2:0] slot(input logic [PW-1:0] p);
      return p[PW-2:0];
   endfunction

   // ----------------------------------------------------------------
   // resets, handshakes and outputs
   // ----------------------------------------------------------------
   assign rx_rst = rx_digital_rst | q.ctrl[CTRL_RX_RST_BIT];
   assign tx_rst = tx_digital_rst | q.ctrl[CTRL_TX_RST_BIT];

   // readies drop while frozen so no item is taken without a state change
   assign s_axi_awready = clk_en && !q.aw_got && !q.bvalid;
   assign s_axi_wready  = clk_en && !q.w_got && !q.bvalid;
   assign s_axi_arready = clk_en && !q.rvalid;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;

   assign rx_out_valid = clk_en && !rx_rst && fifo_level(q.rx_wp, q.rx_rp) != '0;
   assign rx_out_word  = q.rx_mem[slot(q.rx_rp)];
   assign tx_in_ready  = clk_en && !tx_rst
                         && fifo_level(q.tx_wp, q.tx_rp) != PW'(DEPTH);

   // transmit symbol selection feeding the encoder
   always_comb begin
      enc_go    = tx_sym_strobe;
      enc_comma = 1'b0;
      enc_byte  = q.tx_mem[slot(q.tx_rp)][TX_BYTE_W-1:0];
      if (q.sync_cnt != 2'h0) begin
         enc_comma = 1'b1;
      end else if (q.tx_phase) begin
         enc_byte = q.tx_hi;
      end else if (fifo_level(q.tx_wp, q.tx_rp) == '0) begin
         enc_comma = 1'b1;                                       // idle comma on underrun
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic       wr_ok;
      logic       rd_ok;
      logic       push;
      logic [RX_WORD_W-1:0] word;
      d     = q;
      wr_ok = 1'b0;
      rd_ok = 1'b0;
      push  = 1'b0;
      word  = '0;

      // write address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_got = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.aw_got && q.w_got) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = RESP_OKAY;
         wr_ok    = 1'b1;
         if (q.awaddr[7:2] == CTRL_OFFSET[7:2]) begin
            if (q.wstrb[0]) begin
               d.ctrl = q.wdata[CTRL_WIDTH-1:0];
            end
         end else if (q.awaddr[7:2] != STATUS_OFFSET[7:2]) begin
            d.bresp = RESP_SLVERR;
            wr_ok   = 1'b0;
         end
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      // status flags clear by writing one; a new event below wins
      if (wr_ok && q.awaddr[7:2] == STATUS_OFFSET[7:2] && q.wstrb[0]) begin
         if (q.wdata[STAT_RX_OVF_BIT]) begin
            d.rx_ovf = 1'b0;
         end
         if (q.wdata[STAT_TX_UNF_BIT]) begin
            d.tx_unf = 1'b0;
         end
      end

      // read channel
      if (s_axi_arvalid && s_axi_arready) begin
         d.rvalid = 1'b1;
         d.rdata  = '0;
         d.rresp  = RESP_OKAY;
         rd_ok    = 1'b1;
         if (s_axi_araddr[7:2] == CTRL_OFFSET[7:2]) begin
            d.rdata[CTRL_WIDTH-1:0] = q.ctrl;
         end else if (s_axi_araddr[7:2] == STATUS_OFFSET[7:2]) begin
            d.rdata[STAT_RX_OVF_BIT] = q.rx_ovf;
            d.rdata[STAT_TX_UNF_BIT] = q.tx_unf;
            d.rdata[STAT_RX_LEVEL_LSB +: PW] = fifo_level(q.rx_wp, q.rx_rp);
            d.rdata[STAT_TX_LEVEL_LSB +: PW] = fifo_level(q.tx_wp, q.tx_rp);
            d.rdata[STAT_SYNC_BIT] = (q.sync_cnt != 2'h0);
            d.rdata[STAT_RD_BIT]   = enc_rd;
         end else begin
            d.rresp = RESP_SLVERR;
         end
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end

      // receive: pair symbols when deserializing, else pass each one
      if (rx_rst) begin
         d.rx_wp   = '0;
         d.rx_rp   = '0;
         d.rx_half = 1'b0;
      end else begin
         if (rx_sym_valid) begin
            if (!q.ctrl[CTRL_DESER_EN_BIT]) begin
               push = 1'b1;
               word = deser_pack(rx_sym_in, '0, q.ctrl[CTRL_RX_MODE_LSB +: 2]);
            end else if (!q.rx_half) begin
               d.rx_half = 1'b1;
               d.rx_lo   = rx_sym_in;
            end else begin
               d.rx_half = 1'b0;
               push      = 1'b1;
               word      = deser_pack(q.rx_lo, rx_sym_in, q.ctrl[CTRL_RX_MODE_LSB +: 2]);
            end
         end
         if (rx_out_valid && rx_out_ready) begin
            d.rx_rp = q.rx_rp + PW'(1);
         end
         if (push) begin
            if (fifo_level(q.rx_wp, q.rx_rp) == PW'(DEPTH)) begin
               d.rx_ovf = 1'b1;                                  // pointers collided
            end else begin
               d.rx_mem[slot(q.rx_wp)] = word;
               d.rx_wp = q.rx_wp + PW'(1);
            end
         end
      end

      // transmit fifo write, flags stored beside their byte
      if (tx_in_valid && tx_in_ready) begin
         d.tx_mem[slot(q.tx_wp)] = {tx_in_fval[1], tx_in_force[1], tx_in_ctrl[1],
                                    tx_in_data[19:10],
                                    tx_in_fval[0], tx_in_force[0], tx_in_ctrl[0],
                                    tx_in_data[9:0]};
         d.tx_wp = q.tx_wp + PW'(1);
      end

      // transmit read side paced by the pll symbol strobe
      if (tx_rst) begin
         d.tx_wp    = '0;
         d.tx_rp    = '0;
         d.tx_phase = 1'b0;
         d.sync_cnt = SYNC_COUNT;
      end else if (tx_sym_strobe) begin
         if (q.sync_cnt != 2'h0) begin
            d.sync_cnt = q.sync_cnt - 2'h1;
         end else if (q.tx_phase) begin
            d.tx_phase = 1'b0;
         end else if (fifo_level(q.tx_wp, q.tx_rp) == '0) begin
            d.tx_unf = 1'b1;
         end else begin
            d.tx_rp    = q.tx_rp + PW'(1);
            d.tx_hi    = q.tx_mem[slot(q.tx_rp)][2*TX_BYTE_W-1:TX_BYTE_W];
            d.tx_phase = q.ctrl[CTRL_SER_EN_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q          <= '0;
         q.ctrl     <= CTRL_RESET;
         q.sync_cnt <= SYNC_COUNT;
      end else if (clk_en) begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // encoder
   // ----------------------------------------------------------------
   tpcsf_encoder tpcsf_encoder_inst (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .clk_en     (clk_en),
      .tx_rst     (tx_rst),
      .go         (enc_go),
      .send_comma (enc_comma),
      .raw        (q.ctrl[CTRL_ENC_BYPASS_BIT]),
      .data_in    (enc_byte[9:0]),
      .ctrl_in    (enc_byte[10]),
      .force_disp (enc_byte[11]),
      .force_val  (enc_byte[12]),
      .sym_out    (tx_sym_out),
      .rd_pos     (enc_rd)
   );

endmodule

// >>> tb/tpcsf_datapath_assertions.sv
// checker on the fabric datapath top-level ports
module tpcsf_datapath_chk
   import tpcsf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
)
(
   input logic        clk,
   input logic        sys_rst,
   input logic        clk_en,
   input logic        s_axi_awready,
   input logic        s_axi_wready,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic [31:0] s_axi_rdata,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   input logic        rx_digital_rst,
   input logic        tx_digital_rst,
   input logic        rx_out_valid,
   input logic        tx_in_ready,
   input logic        tx_sym_strobe,
   input logic [9:0]  tx_sym_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // --------
   // properties
   // --------
   // single domain, so one clocking and one reset gate
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   AST_TX_COMMA: assert property (tx_digital_rst && clk_en |=> tx_sym_out == K28_5_NEG)
      else $error("no comma in tx reset");
   AST_TX_RST_READY: assert property (tx_digital_rst |-> !tx_in_ready)
      else $error("tx ready in reset");
   AST_RX_RST_VALID: assert property (rx_digital_rst |-> !rx_out_valid)
      else $error("rx valid in reset");
   AST_RX_FLUSH: assert property (rx_digital_rst ##1 !rx_digital_rst |-> !rx_out_valid)
      else $error("rx fifo not flushed");
   AST_TX_STANDS: assert property (
      (!tx_sym_strobe && !tx_digital_rst) [*2] |=> $stable(tx_sym_out))
      else $error("symbol moved without strobe");
   AST_B_HOLD: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   AST_R_HOLD: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken with answer pending");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (rx_out_valid);
   cover property ($fell(tx_digital_rst));
endmodule
bind tpcsf_datapath tpcsf_datapath_chk #(.DEPTH(DEPTH)) tpcsf_datapath_chk_inst (.clk, .sys_rst,
   .clk_en, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_digital_rst, .tx_digital_rst, .rx_out_valid,
   .tx_in_ready, .tx_sym_strobe, .tx_sym_out);

// >>> tb/tpcsf_fabric_model.sv
// fabric user logic model: receive word sink with stall
module tpcsf_fabric_model
   import tpcsf_pkg::*;
(
   input  logic                 clk,
   input  logic                 stall,
   input  logic                 rx_out_valid,
   input  logic [RX_WORD_W-1:0] rx_out_word,
   output logic                 rx_out_ready = 1'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [RX_WORD_W-1:0] got [$];
   // runs on the channel clock itself, so no rate mismatch can arise
   always @(posedge clk) begin
      if (rx_out_valid && rx_out_ready) got.push_back(rx_out_word);
      rx_out_ready <= !stall;
   end
endmodule

// >>> tb/tpcsf_datapath_tb.sv
// self-checking bench for the fabric datapath
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module tpcsf_datapath_tb
   import tpcsf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] KN = K28_5_NEG;
   localparam logic [9:0] KP = ~K28_5_NEG;
   // sync commas, four words low byte first, then an underrun comma
   localparam logic [9:0] SEQ [12] = '{KN, KP, KN, KP, 10'h0ea, 10'h2aa, KN, KN, 10'h2aa,
      10'h2aa, 10'h2aa, KP};
   // {fval, force, ctrl, data} per queued word
   localparam logic [25:0] TXW [4] = '{26'h012f0bc, 26'h022f0b5, 26'h052d4bc, 26'h002d4b5};
   int fail_count = 0, tests_run = 0;
   logic clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, stall = 1'h1, s_axi_awvalid = 1'h0;
   logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic rx_digital_rst = 1'h1, tx_digital_rst = 1'h1, rx_sym_valid = 1'h0, tx_in_valid = 1'h0;
   logic tx_sym_strobe = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, rx_out_valid, rx_out_ready, tx_in_ready;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr, tx_in_ctrl = 2'h0, tx_in_force = 2'h0;
   logic [1:0] tx_in_fval = 2'h0;
   logic [RX_SYM_W-1:0] rx_sym_in = 13'h0;
   logic [RX_WORD_W-1:0] rx_out_word;
   logic [19:0] tx_in_data = 20'h0;
   logic [9:0] tx_sym_out;
   always #5ns clk = ~clk;
   tpcsf_datapath tpcsf_datapath_inst (.clk, .sys_rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_digital_rst, .tx_digital_rst, .rx_sym_valid,
      .rx_sym_in, .rx_out_valid, .rx_out_ready, .rx_out_word, .tx_in_valid, .tx_in_ready,
      .tx_in_data, .tx_in_ctrl, .tx_in_force, .tx_in_fval, .tx_sym_strobe, .tx_sym_out);
   tpcsf_fabric_model tpcsf_fabric_model_inst (.clk, .stall, .rx_out_valid, .rx_out_word,
      .rx_out_ready);
   // --------
   // bus and stream tasks
   // --------
   // address and data offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw;
      ta = 1'h0;
      tw = 1'h0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(negedge clk);
         ta = ta || s_axi_awready;
         tw = tw || s_axi_wready;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
      end while (!(ta && tw));
      while (!s_axi_bvalid) @(negedge clk);
      @(posedge clk);
      s_axi_bready <= 1'h1;
      @(negedge clk);
      `CHK("bresp", RESP_OKAY, s_axi_bresp)
      @(posedge clk);
      s_axi_bready <= 1'h0;
   endtask
   // ready raised late on purpose so the answer must stand
   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(negedge clk); while (!s_axi_arready);
      @(posedge clk);
      s_axi_arvalid <= 1'h0;
      while (!s_axi_rvalid) @(negedge clk);
      @(posedge clk);
      s_axi_rready <= 1'h1;
      @(negedge clk);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      s_axi_rready <= 1'h0;
   endtask
   task automatic rxs(input logic [RX_SYM_W-1:0] s);
      @(posedge clk);
      rx_sym_valid <= 1'h1;
      rx_sym_in <= s;
      @(posedge clk);
      rx_sym_valid <= 1'h0;
      rx_sym_in <= ~s;
   endtask
   task automatic txp(input logic [25:0] w);
      @(posedge clk);
      tx_in_valid <= 1'h1;
      {tx_in_fval, tx_in_force, tx_in_ctrl, tx_in_data} <= w;
      do @(negedge clk); while (!tx_in_ready);
      @(posedge clk);
      tx_in_valid <= 1'h0;
      tx_in_data <= ~w[19:0];
   endtask
   task automatic tsym(input logic [9:0] e);
      @(posedge clk);
      tx_sym_strobe <= 1'h1;
      @(posedge clk);
      tx_sym_strobe <= 1'h0;
      @(negedge clk);
      @(negedge clk);
      `CHK("symbol", e, tx_sym_out)
   endtask
   task automatic stop_test();
      if (fail_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // --------
   // test sequence
   // --------
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'h0;
      @(posedge clk);
      rx_digital_rst <= 1'h0;
      axr(CTRL_OFFSET);
      `CHK("ctrl", 32'h3, rd)
      axr(8'h08);
      `CHK("resp", RESP_SLVERR, rr)
      // stalled sink: five pairs, the fifth must be dropped
      rxs(13'h1911);
      rxs(13'h1e22);
      for (int i = 1; i < 5; i++) begin
         rxs(13'(i));
         rxs(13'(i));
      end
      axr(STATUS_OFFSET);
      `CHK("overflow", 1'h1, rd[STAT_RX_OVF_BIT])
      stall <= 1'h0;
      repeat (12) @(posedge clk);
      `CHK("depth", 4, tpcsf_fabric_model_inst.got.size())
      `CHK("pair", 26'h0292211, tpcsf_fabric_model_inst.got[0])
      `CHK("last", 26'h0000303, tpcsf_fabric_model_inst.got[3])
      axw(CTRL_OFFSET, 32'h13);
      rxs(13'h02a8);
      rxs(13'h0555);
      repeat (6) @(posedge clk);
      `CHK("wide", 26'h02556a8, tpcsf_fabric_model_inst.got[4])
      `CHK("align", 2'h2, tpcsf_fabric_model_inst.got[4][21:20])
      axw(CTRL_OFFSET, 32'h0a);
      rxs(13'h1f5a);
      repeat (4) @(posedge clk);
      `CHK("single", 26'h155005a, tpcsf_fabric_model_inst.got[5])
      tsym(KN);
      @(posedge clk);
      tx_digital_rst <= 1'h0;
      for (int i = 0; i < 4; i++) txp(TXW[i]);
      @(negedge clk);
      `CHK("full", 1'h0, tx_in_ready)
      for (int i = 0; i < 12; i++) tsym(SEQ[i]);
      axr(STATUS_OFFSET);
      `CHK("underrun", 1'h1, rd[STAT_TX_UNF_BIT])
      axw(STATUS_OFFSET, 32'h3);
      axr(STATUS_OFFSET);
      `CHK("cleared", 2'h0, rd[1:0])
      tx_digital_rst <= 1'h1;
      tsym(KN);
      @(posedge clk);
      tx_digital_rst <= 1'h0;
      for (int i = 0; i < 3; i++) tsym(SEQ[i]);
      stop_test();
   end
   // watchdog far beyond the couple of hundred cycles the sequence needs
   initial begin
      #100us;
      fail_count++;
      stop_test();
   end
endmodule
